// ===== tcs_consts.vh
// register map, field positions and reset values of the three-channel timer
// Summary of operation
// - three channels, each a 32-bit up counter
// - interval mode available on channels 0, 1, 2
// - pulse output only on channels 0 and 1
// - watchdog mode only on channel 2
// - two timer pins, count input, watchdog reset
// - divide codes 000..111 give /2 to /256
// - source bit and divide code pick clock
// - internal bus clock is system clock over two
// - one count input shared by all channels
// - edge select bit picks rising or falling
// - enable starts, clear stops, optional zeroing
// - mode 00 interval, 01 pulse, 10 watchdog
`ifndef TCS_CONSTS_VH
`define TCS_CONSTS_VH
// bus widths
`define TCS_AW 8
`define TCS_DW 32
`define TCS_CNT_W 32
// per-channel register block, channel n starts at n times the stride
`define TCS_CH_STRIDE 8'h20
`define TCS_OFF_CTRL 8'h00
`define TCS_OFF_DIV 8'h04
`define TCS_OFF_CMPA 8'h08
`define TCS_OFF_CMPB 8'h0C
`define TCS_OFF_CNT 8'h10
// shared registers
`define TCS_OFF_STAT 8'h80
`define TCS_OFF_MASK 8'h84
`define TCS_OFF_WDOG 8'h88
// control register fields
`define TCS_CTRL_W 7
`define TCS_B_CE 0
`define TCS_B_ZERO_EN 1
`define TCS_B_SRC_SEL 2
`define TCS_B_EDGE 3
`define TCS_F_MODE_LO 4
`define TCS_F_MODE_HI 5
`define TCS_B_FFI 6
// timer mode encodings
`define TCS_MODE_INTERVAL 2'h0
`define TCS_MODE_PULSE 2'h1
`define TCS_MODE_WDOG 2'h2
// reset values
`define TCS_CTRL_RST 7'h00
`define TCS_DIV_RST 3'h0
`define TCS_CMP_RST 32'hFFFFFFFF
`define TCS_STAT_W 6
// internal bus clock is the system clock divided by this
`define TCS_IBCLK_DIV 2
// prescaler depth: taps divide by 2 up to 256
`define TCS_PRE_W 8
`define TCS_DIV_CODE_W 3
// highest count input rate, percent of the internal bus clock
`define TCS_EXT_MAX_PCT 45
`endif

// ===== tcs_prescale.v
// internal bus clock enable and power-of-two prescaler taps
`timescale 1ns/100ps
`include "tcs_consts.vh"
module tcs_prescale #(
  parameter PRE_W = `TCS_PRE_W
) (
  input wire pclk,
  input wire presetn,
  output wire ibclk_en,
  output wire [PRE_W-1:0] tap
);
  reg ibclk_ph_q; // phase of the half-rate internal bus clock
  reg [PRE_W-1:0] pre_q; // ripple-free prescale counter

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ibclk_ph_q <= 1'b0;
    end else begin
      ibclk_ph_q <= ~ibclk_ph_q;
    end
  end
  assign ibclk_en = ibclk_ph_q;

  // counter advances once per internal bus clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= {PRE_W{1'b0}};
    end else if (ibclk_en) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  genvar k;
  generate
    for (k = 0; k < PRE_W; k = k + 1) begin : g_tap
      // tap k fires once every 2^(k+1) internal bus clocks
      assign tap[k] = ibclk_en & (&pre_q[k:0]);
    end
  endgenerate
endmodule

// ===== tcs_timer.v
// three-channel timer with clock select, pulse outputs, watchdog and apb slave
`timescale 1ns/100ps
`include "tcs_consts.vh"
module tcs_timer #(
  parameter NCH = 3,
  parameter CNT_W = `TCS_CNT_W
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`TCS_AW-1:0] paddr,
  input wire [`TCS_DW-1:0] pwdata,
  output wire [`TCS_DW-1:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire external_count_input,
  output wire [1:0] timer_out,
  output wire watchdog_reset_out_n,
  output wire irq
);
  // writes land at the access edge; reads are taken one cycle earlier
  // access phase write and setup phase read strobes
  wire wr_acc = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;

  // channel blocks sit at stride multiples; shared registers lie above them
  // true when addr hits register off of channel ch
  function hit;
    input [`TCS_AW-1:0] addr;
    input [1:0] ch;
    input [`TCS_AW-1:0] off;
    reg [`TCS_AW-1:0] base;
    begin
      base = `TCS_CH_STRIDE * ch;
      hit = (addr == base + off);
    end
  endfunction

  // one prescaler keeps channels on the same divide code in step
  // tick enables arrive at the internal bus clock rate or slower
  // prescaler shared by all channels
  wire ibclk_en;
  wire [`TCS_PRE_W-1:0] tap;
  tcs_prescale #(
    .PRE_W(`TCS_PRE_W)
  ) u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .ibclk_en(ibclk_en),
    .tap(tap)
  );

  // reset level 0 matches the idle input, so no false edge follows reset
  // count input synchroniser and edge history
  reg ext_s1_q; // first stage, read only by the second
  reg ext_s2_q; // synchronised level
  reg ext_s3_q; // previous synchronised level

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_count_input;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // an edge shows here two pclk after the input moves
  // one-cycle edge pulses
  wire ext_rise = ext_s2_q & ~ext_s3_q;
  wire ext_fall = ~ext_s2_q & ext_s3_q;

  // shared interrupt status, mask and watchdog flag
  reg [`TCS_STAT_W-1:0] stat_q;
  reg [`TCS_STAT_W-1:0] stat_d;
  reg [`TCS_STAT_W-1:0] mask_q;
  reg wdog_q; // watchdog reset latched until presetn

  // per-channel results gathered into flat buses
  wire [NCH*`TCS_CTRL_W-1:0] ctrl_all;
  wire [NCH*`TCS_DIV_CODE_W-1:0] div_all;
  wire [NCH*CNT_W-1:0] cmpa_all;
  wire [NCH*CNT_W-1:0] cmpb_all;
  wire [NCH*CNT_W-1:0] cnt_all;
  wire [NCH-1:0] ev_a; // compare a match
  wire [NCH-1:0] ev_b; // compare b match
  wire [NCH-1:0] ff_all; // pulse flip-flops
  wire [NCH-1:0] pg_act; // channel runs as pulse generator
  wire wd_act; // channel 2 runs as watchdog
  wire wd_fire; // watchdog compare match
  wire wd_act_w; // watchdog mode, driven inside the channel loop

  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      // mode capability per channel
      localparam PG_OK = (i < 2);
      localparam WD_OK = (i == 2);
      // channel number at full width, its low bits select the block
      localparam [31:0] CH_NUM = i;
      reg [`TCS_CTRL_W-1:0] ctrl_q; // control register
      reg [`TCS_DIV_CODE_W-1:0] div_q; // divide code register
      reg [CNT_W-1:0] cmpa_q; // compare a
      reg [CNT_W-1:0] cmpb_q; // compare b
      reg [CNT_W-1:0] cnt_q; // counter
      reg [CNT_W-1:0] cnt_d;
      reg ff_q; // pulse output flip-flop
      reg ff_d;
      wire [1:0] mode = ctrl_q[`TCS_F_MODE_HI:`TCS_F_MODE_LO];
      // pulse on ch2, watchdog on ch0 or ch1 and code 11 run as interval
      // pulse mode channels
      wire is_pg = PG_OK && (mode == `TCS_MODE_PULSE);
      wire is_wd = WD_OK && (mode == `TCS_MODE_WDOG);
      wire is_iv = ~is_pg & ~is_wd;
      wire en = ctrl_q[`TCS_B_CE];
      wire ext_tick = ctrl_q[`TCS_B_EDGE] ? ext_rise : ext_fall;
      wire int_tick = tap[div_q];
      wire tick = en & (ctrl_q[`TCS_B_SRC_SEL] ? int_tick : ext_tick);
      // compares look at the count before this tick adds one
      wire m_a = tick & (cnt_q == cmpa_q);
      wire m_b = tick & is_pg & (cnt_q == cmpb_q);

      // register writes from the bus
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl_q <= `TCS_CTRL_RST;
          div_q <= `TCS_DIV_RST;
          cmpa_q <= `TCS_CMP_RST;
          cmpb_q <= `TCS_CMP_RST;
        end else if (wr_acc) begin
          if (hit(paddr, CH_NUM[1:0], `TCS_OFF_CTRL)) begin
            ctrl_q <= pwdata[`TCS_CTRL_W-1:0];
          end
          if (hit(paddr, CH_NUM[1:0], `TCS_OFF_DIV)) begin
            div_q <= pwdata[`TCS_DIV_CODE_W-1:0];
          end
          if (hit(paddr, CH_NUM[1:0], `TCS_OFF_CMPA)) begin
            cmpa_q <= pwdata;
          end
          if (hit(paddr, CH_NUM[1:0], `TCS_OFF_CMPB)) begin
            cmpb_q <= pwdata;
          end
        end
      end

      // counter and pulse flip-flop next state
      always @* begin
        cnt_d = cnt_q;
        ff_d = ff_q;
        if (!is_pg) begin
          // idle level follows the initial-state bit
          // so a later switch to pulse mode starts from a known level
          ff_d = ctrl_q[`TCS_B_FFI];
        end
        if (!en && ctrl_q[`TCS_B_ZERO_EN]) begin
          // held at zero for as long as the enable stays low
          cnt_d = {CNT_W{1'b0}};
        end else if (m_b) begin
          // pulse period end: toggle and restart
          cnt_d = {CNT_W{1'b0}};
          ff_d = ~ff_q;
        end else if (m_a && is_iv) begin
          // interval period end restarts the count
          cnt_d = {CNT_W{1'b0}};
        end else if (tick) begin
          cnt_d = cnt_q + 1'b1;
          if (m_a && is_pg) begin
            ff_d = ~ff_q;
          end
        end
      end

      // the pin register adds one more pclk after ff_q
      // counter and pulse flip-flop registers
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q <= {CNT_W{1'b0}};
          ff_q <= 1'b0;
        end else begin
          cnt_q <= cnt_d;
          ff_q <= ff_d;
        end
      end

      // flatten for the shared logic
      assign ctrl_all[i*`TCS_CTRL_W +: `TCS_CTRL_W] = ctrl_q;
      assign div_all[i*`TCS_DIV_CODE_W +: `TCS_DIV_CODE_W] = div_q;
      assign cmpa_all[i*CNT_W +: CNT_W] = cmpa_q;
      assign cmpb_all[i*CNT_W +: CNT_W] = cmpb_q;
      assign cnt_all[i*CNT_W +: CNT_W] = cnt_q;
      assign ev_a[i] = m_a;
      assign ev_b[i] = m_b;
      assign ff_all[i] = ff_q;
      assign pg_act[i] = is_pg;
      if (WD_OK) begin : g_wd
        assign wd_act_w = is_wd;
      end
    end
  endgenerate

  // watchdog mode flag from channel 2
  assign wd_act = wd_act_w;
  // the channel counts on past the match; the latch holds the event
  assign wd_fire = wd_act & ev_a[2];

  // bit 5 stays zero: channel 2 has no pulse mode, so no b event
  // status and mask registers; set beats a write-one clear
  always @* begin
    stat_d = stat_q;
    if (wr_acc && paddr == `TCS_OFF_STAT) begin
      stat_d = stat_q & ~pwdata[`TCS_STAT_W-1:0];
    end
    stat_d = stat_d | {ev_b[2], ev_a[2], ev_b[1], ev_a[1], ev_b[0], ev_a[0]};
  end

  // status, mask and watchdog latch registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= {`TCS_STAT_W{1'b0}};
      mask_q <= {`TCS_STAT_W{1'b0}};
      wdog_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      if (wr_acc && paddr == `TCS_OFF_MASK) begin
        mask_q <= pwdata[`TCS_STAT_W-1:0];
      end
      // only presetn clears the latch, software cannot release the pin
      // watchdog reset latch
      if (wd_fire) begin
        wdog_q <= 1'b1;
      end
    end
  end

  // stays high until software clears the status bit or masks it
  // level interrupt from unmasked status
  assign irq = |(stat_q & mask_q);

  // driven from the latch register, so it cannot glitch
  // watchdog reset pin, active low
  assign watchdog_reset_out_n = ~wdog_q;

  // registered so the pins carry no decode glitches
  // timer pins from a register
  reg [1:0] tout_q;
  reg [1:0] tout_d;

  // pulse pins, high in watchdog, low in interval
  always @* begin
    tout_d = 2'h0;
    if (wd_act) begin
      tout_d = 2'h3;
    end else begin
      tout_d = pg_act[1:0] & ff_all[1:0];
    end
  end

  // timer pin register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout_q <= 2'h0;
    end else begin
      tout_q <= tout_d;
    end
  end
  assign timer_out = tout_q;

  // read mux and address check
  reg [`TCS_DW-1:0] rd_d;
  reg rd_ok;
  integer c;

  // the map has no overlaps, so the order of the tests does not matter
  // decode of the current address
  always @* begin
    rd_d = {`TCS_DW{1'b0}};
    rd_ok = 1'b0;
    for (c = 0; c < NCH; c = c + 1) begin
      if (hit(paddr, c[1:0], `TCS_OFF_CTRL)) begin
        rd_d = {{(`TCS_DW-`TCS_CTRL_W){1'b0}}, ctrl_all[c*`TCS_CTRL_W +: `TCS_CTRL_W]};
        rd_ok = 1'b1;
      end
      if (hit(paddr, c[1:0], `TCS_OFF_DIV)) begin
        rd_d = {{(`TCS_DW-`TCS_DIV_CODE_W){1'b0}}, div_all[c*`TCS_DIV_CODE_W +: `TCS_DIV_CODE_W]};
        rd_ok = 1'b1;
      end
      if (hit(paddr, c[1:0], `TCS_OFF_CMPA)) begin
        rd_d = cmpa_all[c*CNT_W +: CNT_W];
        rd_ok = 1'b1;
      end
      if (hit(paddr, c[1:0], `TCS_OFF_CMPB)) begin
        rd_d = cmpb_all[c*CNT_W +: CNT_W];
        rd_ok = 1'b1;
      end
      if (hit(paddr, c[1:0], `TCS_OFF_CNT)) begin
        rd_d = cnt_all[c*CNT_W +: CNT_W];
        rd_ok = 1'b1;
      end
    end
    if (paddr == `TCS_OFF_STAT) begin
      rd_d = {{(`TCS_DW-`TCS_STAT_W){1'b0}}, stat_q};
      rd_ok = 1'b1;
    end
    if (paddr == `TCS_OFF_MASK) begin
      rd_d = {{(`TCS_DW-`TCS_STAT_W){1'b0}}, mask_q};
      rd_ok = 1'b1;
    end
    if (paddr == `TCS_OFF_WDOG) begin
      rd_d = {{(`TCS_DW-1){1'b0}}, wdog_q};
      rd_ok = 1'b1;
    end
  end

  // read data captured in the setup cycle
  // so that the access cycle needs no wait state
  reg [`TCS_DW-1:0] prdata_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= {`TCS_DW{1'b0}};
    end else if (rd_setup) begin
      prdata_q <= rd_d;
    end
  end
  assign prdata = prdata_q;

  // counter and watchdog latch are read only; writes to them are dropped quietly
  // zero wait state; unmapped access reports an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~rd_ok;
endmodule

// ===== tcs_event_source.sv
// event source model that drives the count input
`timescale 1ns/100ps
module tcs_event_source (
  input wire pclk,
  input wire go,
  input wire [3:0] n_edge,
  output reg ext_in,
  output reg busy
);
  reg [3:0] left_q; // pulses still to send
  reg [2:0] ph_q; // half period counter
  initial begin
    ext_in = 1'b0;
    busy = 1'b0;
    left_q = 4'h0;
    ph_q = 3'h0;
  end
  always @(posedge pclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      left_q <= n_edge;
      ph_q <= 3'h0;
    end else if (busy) begin
      ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
      // line toggles, a pulse ends on its fall
      if (ph_q == 3'h4) begin
        ext_in <= ~ext_in;
        if (ext_in && left_q == 4'h1) busy <= 1'b0;
        if (ext_in) left_q <= left_q - 4'h1;
      end
    end
  end
endmodule

// ===== tcs_timer_properties.sv
// port checks of the timer
`timescale 1ns/100ps
`include "tcs_consts.vh"
module tcs_timer_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [`TCS_AW-1:0] paddr,
  input wire [`TCS_DW-1:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [1:0] timer_out,
  input wire watchdog_reset_out_n,
  input wire irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase of a transfer
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_access: assert property (pslverr |-> s_access) else $error("pslverr outside access");
  a_err_unmapped: assert property (s_access ##0 (paddr > 8'h88) |-> pslverr) else $error("no pslverr");
  a_err_mapped: assert property (s_access ##0 (paddr == 8'h10 || paddr == 8'h88) |-> !pslverr)
    else $error("pslverr on mapped");
  a_read_stands: assert property ((!psel || penable) |=> $stable(prdata)) else $error("prdata moved");
  a_wdog_sticky: assert property (!watchdog_reset_out_n |=> !watchdog_reset_out_n)
    else $error("watchdog reset released");
  a_wdog_pins: assert property ($fell(watchdog_reset_out_n) |-> timer_out == 2'b11)
    else $error("pins not high");
  a_reset_quiet: assert property ($rose(presetn) |-> !irq && timer_out == 2'b00) else $error("outputs busy");
endmodule
bind tcs_timer tcs_timer_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_out(timer_out),
  .watchdog_reset_out_n(watchdog_reset_out_n), .irq(irq));

// ===== tcs_timer_test.sv
// self-checking bench of the timer
`timescale 1ns/100ps
`include "tcs_consts.vh"
module tcs_timer_test;
  reg pclk, presetn, psel, penable, pwrite, go, q, err;
  reg [7:0] paddr, cb;
  reg [31:0] pwdata, rd, rd2;
  reg [3:0] n_edge;
  reg [40:0] rows [0:9]; // address, value, error
  wire [31:0] prdata;
  wire pready, pslverr, ext_in, busy, wdn, irq;
  wire [1:0] timer_out;
  integer n_mismatch = 0, n_compared = 0, i, p;
  tcs_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_input(ext_in), .timer_out(timer_out), .watchdog_reset_out_n(wdn), .irq(irq));
  tcs_event_source src (.pclk(pclk), .go(go), .n_edge(n_edge), .ext_in(ext_in), .busy(busy));
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // send n pulses on the count input
  task pulse(input [3:0] n);
    @(posedge pclk);
    go <= 1'b1;
    n_edge <= n;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy) @(posedge pclk);
    repeat (8) @(posedge pclk);
  endtask
  task conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // watchdog of the run
  initial begin
    #1000000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end
  initial begin
    {presetn, psel, penable, pwrite, go, paddr, pwdata, n_edge} = 0;
    rows[0] = {8'h00, 32'h0, 1'b0};
    rows[1] = {8'h04, 32'h0, 1'b0};
    rows[2] = {8'h08, 32'hFFFFFFFF, 1'b0};
    rows[3] = {8'h2C, 32'hFFFFFFFF, 1'b0};
    rows[4] = {8'h50, 32'h0, 1'b0};
    rows[5] = {8'h80, 32'h0, 1'b0};
    rows[6] = {8'h84, 32'h0, 1'b0};
    rows[7] = {8'h88, 32'h0, 1'b0};
    rows[8] = {8'h8C, 32'h0, 1'b1};
    rows[9] = {8'h34, 32'h0, 1'b1};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 10; i = i + 1) begin
      apb(1'b0, rows[i][40:33], 32'h0);
      chk("reset value", rd, rows[i][32:1]);
      chk("slave error", {31'h0, err}, {31'h0, rows[i][0]});
    end
    // one tick per 4 << code pclk
    for (i = 0; i < 8; i = i + 1) begin
      p = 4 << i;
      cb = 8'(i % 3) << 5;
      apb(1'b1, cb | 8'h04, 32'(i));
      apb(1'b1, cb, 32'h07);
      apb(1'b0, cb | 8'h10, 32'h0);
      rd2 = rd;
      repeat (8 * p - 3) @(posedge pclk);
      apb(1'b0, cb | 8'h10, 32'h0);
      chk("tick count", rd - rd2, 32'h8);
      apb(1'b1, cb, 32'h02);
    end
    for (i = 0; i < 2; i = i + 1) begin
      apb(1'b1, 8'h40, 32'h02);
      apb(1'b1, 8'h40, 32'h01 | (32'(i) << 3));
      pulse(4'h6);
      apb(1'b0, 8'h50, 32'h0);
      chk("external count", rd, 32'h6);
    end
    apb(1'b1, 8'h40, 32'h08);
    pulse(4'h3);
    apb(1'b0, 8'h50, 32'h0);
    chk("stopped count", rd, 32'h6);
    apb(1'b1, 8'h40, 32'h0A);
    apb(1'b0, 8'h50, 32'h0);
    chk("zeroed count", rd, 32'h0);
    // interval match sets status, irq masked
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h08, 32'h3);
    apb(1'b1, 8'h00, 32'h07);
    repeat (40) @(posedge pclk);
    chk("masked irq", {31'h0, irq}, 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    chk("status", rd & 32'h1, 32'h1);
    apb(1'b1, 8'h84, 32'h1);
    @(negedge pclk);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, 8'h00, 32'h02);
    apb(1'b1, 8'h80, 32'h3F);
    @(negedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    // pulse pins toggle twice per cycle
    for (i = 0; i < 2; i = i + 1) begin
      cb = 8'(i) << 5;
      apb(1'b1, cb | 8'h04, 32'h0);
      apb(1'b1, cb | 8'h08, 32'h1);
      apb(1'b1, cb | 8'h0C, 32'h3);
      apb(1'b1, cb, 32'h17);
      p = 0;
      @(negedge pclk);
      q = timer_out[i];
      // four periods of sixteen pclk, with room for the tick phase
      repeat (68) begin
        @(negedge pclk);
        if (timer_out[i] !== q) p = p + 1;
        q = timer_out[i];
      end
      chk("pulse toggles", 32'(p), 32'h8);
      apb(1'b1, cb, 32'h02);
    end
    // no pulse on ch2, no watchdog on ch0
    apb(1'b1, 8'h40, 32'h17);
    apb(1'b1, 8'h00, 32'h27);
    repeat (64) @(posedge pclk);
    chk("pins idle", {30'h0, timer_out}, 32'h0);
    chk("no watchdog", {31'h0, wdn}, 32'h1);
    apb(1'b1, 8'h00, 32'h02);
    apb(1'b1, 8'h40, 32'h02);
    apb(1'b1, 8'h44, 32'h0);
    apb(1'b1, 8'h48, 32'h4);
    apb(1'b1, 8'h40, 32'h27);
    p = 0;
    while (wdn !== 1'b0 && p < 200) begin
      @(posedge pclk);
      p = p + 1;
    end
    @(negedge pclk);
    chk("watchdog low", {31'h0, wdn}, 32'h0);
    chk("pins high", {30'h0, timer_out}, 32'h3);
    apb(1'b0, 8'h88, 32'h0);
    chk("watchdog latch", rd, 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("watchdog released", {31'h0, wdn}, 32'h1);
    conclude;
  end
endmodule
